// ---- scg_top.sv ----
/*
 * Output control of a system clock generator: processor, memory, bus,
 * reference and usb-rate clock groups, halt gating and frequency strap.
 * Assumes one 50 MHz ref_clk; outputs run at rates scaled down by the
 * rate scale, and registers are reached over Avalon-MM with waitrequest.
 */
`timescale 1ns/100ps
`include "scg_defs.svh"
module scg_top #(
  parameter int HALF_60  = `SCG_HALF(`SCG_PROC60_KHZ),
  parameter int HALF_66  = `SCG_HALF(`SCG_PROC66_KHZ),
  parameter int HALF_REF = `SCG_HALF(`SCG_REF_KHZ),
  parameter int HALF_USB = `SCG_HALF(`SCG_USB_KHZ)
) (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        mode_select,
  input  wire logic        base_frequency_select,
  input  wire logic        mem6_pin_in,
  output logic             mem6_pin_out,
  output logic             mem6_pin_oe_n,
  input  wire logic        mem7_pin_in,
  output logic             mem7_pin_out,
  output logic             mem7_pin_oe_n,
  output logic [3:0]       processor_clock_outputs,
  output logic [5:0]       memory_clock_outputs,
  output logic [5:0]       gated_bus_clocks,
  output logic             free_bus_clock,
  output logic             interrupt_controller_clock,
  output logic [1:0]       usb_rate_clock,
  output logic [1:0]       reference_clock_outputs
);
  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  if (HALF_60 < 1 || HALF_66 < 1 || HALF_REF < 1 || HALF_USB < 1 ||
      HALF_60 > 1023 || HALF_66 > 1023 || HALF_REF > 1023 || HALF_USB > 1023) begin : g_chk
    $error("scg_top: half-period counts must lie in 1..1023");
  end

  // ----------------------------------------------------------------------
  // Pin synchronisers: mode, strap, pin six, pin seven
  // ----------------------------------------------------------------------
  logic [3:0] sync_a_q;
  logic [3:0] sync_b_q;
  logic       mode_s;
  logic       sel_s;
  logic       pin6_s;
  logic       pin7_s;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      // Halt pins idle high, so no false halt after reset
      sync_a_q <= 4'hc;
      sync_b_q <= 4'hc;
    end else begin
      sync_a_q <= {mem7_pin_in, mem6_pin_in, base_frequency_select, mode_select};
      sync_b_q <= sync_a_q;
    end
  end

  assign mode_s = sync_b_q[0];
  assign sel_s  = sync_b_q[1];
  assign pin6_s = sync_b_q[2];
  assign pin7_s = sync_b_q[3];

  // ----------------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------------
  scg_pkg::scg_cfg_t cfg0_q;
  scg_pkg::scg_cfg_t cfg0_d;
  scg_pkg::scg_cfg_t cfg7_q;
  scg_pkg::scg_cfg_t cfg7_d;
  logic [31:0]       rdata_d;
  logic              wait_d;
  logic              req;
  logic              cpu_run_q;
  logic              bus_run_q;
  logic              sel_q;

  function automatic scg_pkg::scg_cfg_t wr_byte(input scg_pkg::scg_cfg_t old,
                                                 input logic [31:0] wd,
                                                 input logic be0);
    wr_byte = be0 ? wd[7:0] : old;
  endfunction

  assign req = avs_read | avs_write;

  always_comb begin
    cfg0_d  = cfg0_q;
    cfg7_d  = cfg7_q;
    rdata_d = avs_readdata;
    wait_d  = 1'b1;
    if (req && avs_waitrequest) begin
      wait_d  = 1'b0;
      rdata_d = 32'h0000_0000;
      if (avs_address == `SCG_OFS_CFG0) begin
        rdata_d = {24'h00_0000, cfg0_q};
      end else if (avs_address == `SCG_OFS_CFG7) begin
        rdata_d = {24'h00_0000, cfg7_q};
      end else if (avs_address == `SCG_OFS_STATUS) begin
        rdata_d = {28'h000_0000, sel_q, bus_run_q, cpu_run_q, mode_s};
      end
    end else if (avs_write && !avs_waitrequest) begin
      if (avs_address == `SCG_OFS_CFG0) begin
        cfg0_d = wr_byte(cfg0_q, avs_writedata, avs_byteenable[0]);
      end else if (avs_address == `SCG_OFS_CFG7) begin
        cfg7_d = wr_byte(cfg7_q, avs_writedata, avs_byteenable[0]);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      // usb clocks default to full rate
      cfg0_q          <= `SCG_CFG0_RESET;
      cfg7_q          <= `SCG_CFG7_RESET;
      avs_readdata    <= 32'h0000_0000;
      avs_waitrequest <= 1'b1;
    end else begin
      cfg0_q          <= cfg0_d;
      cfg7_q          <= cfg7_d;
      avs_readdata    <= rdata_d;
      avs_waitrequest <= wait_d;
    end
  end

  // ----------------------------------------------------------------------
  // Dividers
  // ----------------------------------------------------------------------
  logic cpu_tick;
  logic ref_tick;
  logic usb_tick;
  scg_pkg::scg_half_t cpu_half;

  assign cpu_half = sel_q ? scg_pkg::scg_half_t'(HALF_66) : scg_pkg::scg_half_t'(HALF_60);

  scg_tick_div #(.W(10)) u_cpu_div (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .half_cnt (cpu_half),
    .tick_q   (cpu_tick)
  );
  scg_tick_div #(.W(10)) u_ref_div (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .half_cnt (scg_pkg::scg_half_t'(HALF_REF)),
    .tick_q   (ref_tick)
  );
  scg_tick_div #(.W(10)) u_usb_div (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .half_cnt (scg_pkg::scg_half_t'(HALF_USB)),
    .tick_q   (usb_tick)
  );

  // ----------------------------------------------------------------------
  // Clock groups and halt gating
  // ----------------------------------------------------------------------
  logic             cpu_free_q, cpu_free_d, bus_free_q, bus_free_d;
  logic             cpu_run_d, bus_run_d, sel_d;
  logic             ref_q, ref_d, u48_q, u48_d, u24_q, u24_d;
  scg_pkg::scg_lat_t cpu_lat_q, cpu_lat_d, bus_lat_q, bus_lat_d;
  logic [1:0]       start_q, start_d;
  logic             cpu_want, bus_want, cpu_rise, bus_rise;
  logic [3:0]       cpu_out_d;
  logic [5:0]       mem_out_d, bus_out_d;
  logic [1:0]       usb_out_d;
  logic             p6_d, p6_oe_d, p7_d, p7_oe_d;

  always_comb begin
    // halt taken from pin six in halt mode
    cpu_want = mode_s | pin6_s;
    // halt taken from pin seven in halt mode
    bus_want = mode_s | pin7_s;
    cpu_rise = cpu_tick & ~cpu_free_q;
    bus_rise = cpu_rise & ~bus_free_q;
    cpu_free_d = cpu_tick ? ~cpu_free_q : cpu_free_q;
    // free bus clock at half processor rate
    bus_free_d = cpu_rise ? ~bus_free_q : bus_free_q;
    ref_d = ref_tick ? ~ref_q : ref_q;
    u48_d = usb_tick ? ~u48_q : u48_q;
    u24_d = (usb_tick & ~u48_q) ? ~u24_q : u24_q;
    cpu_run_d = cpu_run_q;
    cpu_lat_d = 2'h0;
    bus_run_d = bus_run_q;
    bus_lat_d = 2'h0;
    // count edges, then stop at a falling edge
    // restart at a falling edge so a full cycle follows
    if (cpu_want != cpu_run_q) begin
      cpu_lat_d = cpu_lat_q;
      if (cpu_rise && cpu_lat_q < scg_pkg::scg_lat_t'(`SCG_PROC_LAT_EDGES)) begin
        cpu_lat_d = cpu_lat_q + 2'h1;
      end
      if (cpu_tick && cpu_free_q &&
          cpu_lat_q >= scg_pkg::scg_lat_t'(`SCG_PROC_LAT_EDGES)) begin
        cpu_run_d = cpu_want;
        cpu_lat_d = 2'h0;
      end
    end
    // stop only at a bus falling edge
    // restart at a falling edge so a full cycle follows
    // one free rising edge passes first
    if (bus_want != bus_run_q) begin
      bus_lat_d = bus_lat_q;
      if (bus_rise && bus_lat_q < scg_pkg::scg_lat_t'(`SCG_BUS_LAT_EDGES)) begin
        bus_lat_d = bus_lat_q + 2'h1;
      end
      if (cpu_rise && bus_free_q &&
          bus_lat_q >= scg_pkg::scg_lat_t'(`SCG_BUS_LAT_EDGES)) begin
        bus_run_d = bus_want;
        bus_lat_d = 2'h0;
      end
    end
    // strap captured after release of reset
    // strap followed only with all three bits set
    start_d = (start_q == `SCG_STRAP_SETTLE) ? start_q : start_q + 2'h1;
    sel_d   = sel_q;
    if (start_q != `SCG_STRAP_SETTLE || cfg7_q[2:0] == `SCG_CFG7_FOLLOW_ONES) begin
      sel_d = sel_s;
    end
    cpu_out_d = {4{cpu_free_d & cpu_run_d}};
    // memory clocks follow the free processor phase
    mem_out_d = {6{cpu_free_d}};
    bus_out_d = {6{bus_free_d & bus_run_d}};
    // pin six driven as memory clock six
    p6_d    = cpu_free_d & mode_s;
    p6_oe_d = ~mode_s;
    // pin seven driven as memory clock seven
    p7_d    = cpu_free_d & mode_s;
    p7_oe_d = ~mode_s;
    usb_out_d[0] = cfg0_q[`SCG_CFG0_USB0_BIT] ? u24_d : u48_d;
    usb_out_d[1] = cfg0_q[`SCG_CFG0_USB1_BIT] ? u24_d : u48_d;
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      cpu_free_q <= 1'b0;
      bus_free_q <= 1'b0;
      ref_q      <= 1'b0;
      u48_q      <= 1'b0;
      u24_q      <= 1'b0;
      cpu_run_q  <= 1'b1;
      bus_run_q  <= 1'b1;
      cpu_lat_q  <= 2'h0;
      bus_lat_q  <= 2'h0;
      start_q    <= 2'h0;
      sel_q      <= 1'b0;
      processor_clock_outputs    <= 4'h0;
      memory_clock_outputs       <= 6'h00;
      gated_bus_clocks           <= 6'h00;
      free_bus_clock             <= 1'b0;
      interrupt_controller_clock <= 1'b0;
      reference_clock_outputs    <= 2'h0;
      usb_rate_clock             <= 2'h0;
      mem6_pin_out  <= 1'b0;
      mem6_pin_oe_n <= 1'b1;
      mem7_pin_out  <= 1'b0;
      mem7_pin_oe_n <= 1'b1;
    end else begin
      cpu_free_q <= cpu_free_d;
      bus_free_q <= bus_free_d;
      ref_q      <= ref_d;
      u48_q      <= u48_d;
      u24_q      <= u24_d;
      cpu_run_q  <= cpu_run_d;
      bus_run_q  <= bus_run_d;
      cpu_lat_q  <= cpu_lat_d;
      bus_lat_q  <= bus_lat_d;
      start_q    <= start_d;
      sel_q      <= sel_d;
      processor_clock_outputs    <= cpu_out_d;
      memory_clock_outputs       <= mem_out_d;
      gated_bus_clocks           <= bus_out_d;
      free_bus_clock             <= bus_free_d;
      interrupt_controller_clock <= ref_d;
      reference_clock_outputs    <= {2{ref_d}};
      usb_rate_clock             <= usb_out_d;
      mem6_pin_out  <= p6_d;
      mem6_pin_oe_n <= p6_oe_d;
      mem7_pin_out  <= p7_d;
      mem7_pin_oe_n <= p7_oe_d;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  pin6_release_a: assert property (!mode_s |=> mem6_pin_oe_n)
    else $error("pin six driven in halt mode");
  pin6_drive_a: assert property (mode_s |=> !mem6_pin_oe_n && mem6_pin_out == cpu_free_q)
    else $error("pin six not driving memory clock");
  pin7_release_a: assert property (!mode_s |=> mem7_pin_oe_n)
    else $error("pin seven driven in halt mode");
  pin7_drive_a: assert property (mode_s |=> !mem7_pin_oe_n && mem7_pin_out == cpu_free_q)
    else $error("pin seven not driving memory clock");
  proc_stop_low_a: assert property ($fell(cpu_run_q) |-> !cpu_free_q &&
                                    processor_clock_outputs == 4'h0)
    else $error("processor clocks stopped mid cycle");
  proc_start_full_a: assert property ($rose(cpu_run_q) |-> processor_clock_outputs == 4'h0
                                      ##1 !processor_clock_outputs[0] [*1])
    else $error("processor restart not at low phase");
  proc_lat_a: assert property ($changed(cpu_run_q) |-> $past(cpu_lat_q) == 2'h2)
    else $error("processor halt latency wrong");
  bus_stop_low_a: assert property (!bus_run_q |-> gated_bus_clocks == 6'h00)
    else $error("gated bus clocks running while halted");
  bus_lat_a: assert property ($changed(bus_run_q) |-> $past(bus_lat_q) == 2'h1 &&
                              !bus_free_q)
    else $error("bus gating changed without one free edge");
  bus_restart_a: assert property ($rose(bus_run_q) |-> gated_bus_clocks == 6'h00)
    else $error("bus restart not at low phase");
  bus_free_run_a: assert property (1 |-> ##[1:900] $changed(free_bus_clock))
    else $error("free bus clock stalled");
  mem_sync_a: assert property (memory_clock_outputs == {6{cpu_free_q}})
    else $error("memory clocks out of step");
  usb_sel_a: assert property (!cfg0_q[`SCG_CFG0_USB0_BIT] |=> usb_rate_clock[0] == u48_q)
    else $error("usb clock zero not at full rate");
  usb_half_a: assert property (cfg0_q[`SCG_CFG0_USB1_BIT] |=> usb_rate_clock[1] == u24_q)
    else $error("usb clock one not at half rate");
  strap_lock_a: assert property (start_q == `SCG_STRAP_SETTLE &&
                                 cfg7_q[2:0] != `SCG_CFG7_FOLLOW_ONES |=> $stable(sel_q))
    else $error("strap followed while locked");
  strap_take_a: assert property (start_q == `SCG_STRAP_SETTLE &&
                                 cfg7_q[2:0] == `SCG_CFG7_FOLLOW_ONES |=> sel_q == $past(sel_s))
    else $error("strap not followed");
  ref_fixed_a: assert property (reference_clock_outputs == {2{interrupt_controller_clock}}
                                && interrupt_controller_clock == ref_q)
    else $error("reference clocks diverge");
  mode_run_a: assert property (mode_s && cpu_run_q && bus_run_q |=> cpu_run_q && bus_run_q)
    else $error("halt honoured in memory clock mode");

  proc_stop_c: cover property ($fell(cpu_run_q));
  proc_start_c: cover property ($rose(cpu_run_q));
  bus_stop_c: cover property ($fell(bus_run_q));
  strap_change_c: cover property (start_q == `SCG_STRAP_SETTLE && $changed(sel_q));
endmodule

// ---- scg_defs.svh ----
/*
 * Constants of the system clock output gating block: register offsets,
 * reset values, field positions and the rates behind each divider count.
 * Assumes it is included by bare name wherever a constant is needed.
 */
`ifndef SCG_DEFS_SVH
`define SCG_DEFS_SVH

// ----------------------------------------------------------------------
// Register map (byte offsets)
// ----------------------------------------------------------------------
`define SCG_OFS_CFG0          4'h0
`define SCG_OFS_CFG7          4'h4
`define SCG_OFS_STATUS        4'h8

`define SCG_CFG0_RESET        8'h00
`define SCG_CFG7_RESET        8'h07
`define SCG_CFG0_USB0_BIT     2
`define SCG_CFG0_USB1_BIT     3
`define SCG_CFG7_FOLLOW_ONES  3'h7

// ----------------------------------------------------------------------
// Rates and derived half-period counts
// ----------------------------------------------------------------------
`define SCG_CLK_KHZ           50000
`define SCG_RATE_SCALE        100
`define SCG_PROC60_KHZ        60000
`define SCG_PROC66_KHZ        66800
`define SCG_REF_KHZ           14318
`define SCG_USB_KHZ           48000
`define SCG_HALF(f)           ((`SCG_CLK_KHZ * `SCG_RATE_SCALE) / (2 * (f)))
`define SCG_PROC_LAT_EDGES    2
`define SCG_BUS_LAT_EDGES     1
`define SCG_STRAP_SETTLE      2'h3

`endif

// ---- scg_pkg.sv ----
/*
 * Types shared by the clock gating files.
 * Assumes scg_defs.svh is available for the constants.
 */
package scg_pkg;
  typedef logic [9:0] scg_half_t;
  typedef logic [1:0] scg_lat_t;
  typedef logic [7:0] scg_cfg_t;
endpackage

// ---- scg_tick_div.sv ----
/*
 * Programmable divider: one-cycle tick every half_cnt cycles of ref_clk.
 * Assumes half_cnt is at least one and changes only between ticks.
 */
`timescale 1ns/100ps
module scg_tick_div #(
  parameter int W = 10
) (
  input  wire logic         ref_clk,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] half_cnt,
  output logic              tick_q
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic         tick_d;

  if (W < 2) begin : g_chk
    $error("scg_tick_div: W must be at least 2");
  end

  always_comb begin
    tick_d = 1'b0;
    cnt_d  = cnt_q + {{(W-1){1'b0}}, 1'b1};
    if (cnt_q + {{(W-1){1'b0}}, 1'b1} >= half_cnt) begin
      tick_d = 1'b1;
      cnt_d  = '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end
endmodule

// ---- scg_pm_model.sv ----
/*
 * Chipset power-management model that drives the two halt pins.
 * Assumes the bench resolves each pin from both parties' enables.
 */
`timescale 1ns/100ps
module scg_pm_model (
  input  wire logic ref_clk,
  input  wire logic mode_select,
  input  wire logic proc_halt_req,
  input  wire logic bus_halt_req,
  output logic      proc_halt_n,
  output logic      bus_halt_n,
  output logic      drive_en
);
  // ----------------------------------------------------------------
  // Halt drive
  // ----------------------------------------------------------------
  // drive only in halt mode
  always @(posedge ref_clk) begin
    proc_halt_n <= ~proc_halt_req;
    bus_halt_n  <= ~bus_halt_req;
    drive_en    <= ~mode_select;
  end
endmodule

// ---- test_scg_top.sv ----
/*
 * Self-checking bench of the clock output gating block.
 * Assumes scaled half periods and the pm model on the halt pins.
 */
`timescale 1ns/100ps
`include "scg_defs.svh"
module test_scg_top;
  localparam int H60 = 3;
  localparam int H66 = 2;
  localparam int HR  = 5;
  localparam int HU  = 4;
  logic        ref_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        mode_select = 1'b0;
  logic        base_frequency_select = 1'b0;
  logic        proc_req = 1'b0;
  logic        bus_req = 1'b0;
  logic        pm_proc_n, pm_bus_n, pm_en;
  logic        last6 = 1'b0;
  logic        last7 = 1'b0;
  wire         mem6_pin_in, mem7_pin_in;
  logic        mem6_pin_out, mem6_pin_oe_n, mem7_pin_out, mem7_pin_oe_n;
  logic [3:0]  processor_clock_outputs;
  logic [5:0]  memory_clock_outputs, gated_bus_clocks;
  logic        free_bus_clock, interrupt_controller_clock;
  logic [1:0]  usb_rate_clock, reference_clock_outputs;
  int          error_cnt = 0;
  int          checks = 0;
  int          hp = H60;
  logic [31:0] cfg = 32'h0;

  always #10 ref_clk = ~ref_clk;
  // Pin released by both DUT and pm model shows inverse of its last level
  assign mem6_pin_in = !mem6_pin_oe_n ? mem6_pin_out : (pm_en ? pm_proc_n : ~last6);
  assign mem7_pin_in = !mem7_pin_oe_n ? mem7_pin_out : (pm_en ? pm_bus_n : ~last7);
  always @(posedge ref_clk) begin
    last6 <= mem6_pin_in;
    last7 <= mem7_pin_in;
  end

  scg_top #(.HALF_60(H60), .HALF_66(H66), .HALF_REF(HR), .HALF_USB(HU)) i_scg_top (
    .ref_clk(ref_clk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .mode_select(mode_select),
    .base_frequency_select(base_frequency_select), .mem6_pin_in(mem6_pin_in),
    .mem6_pin_out(mem6_pin_out), .mem6_pin_oe_n(mem6_pin_oe_n),
    .mem7_pin_in(mem7_pin_in), .mem7_pin_out(mem7_pin_out),
    .mem7_pin_oe_n(mem7_pin_oe_n), .processor_clock_outputs(processor_clock_outputs),
    .memory_clock_outputs(memory_clock_outputs), .gated_bus_clocks(gated_bus_clocks),
    .free_bus_clock(free_bus_clock),
    .interrupt_controller_clock(interrupt_controller_clock),
    .usb_rate_clock(usb_rate_clock), .reference_clock_outputs(reference_clock_outputs));

  scg_pm_model i_scg_pm_model (
    .ref_clk(ref_clk), .mode_select(mode_select), .proc_halt_req(proc_req),
    .bus_halt_req(bus_req), .proc_halt_n(pm_proc_n), .bus_halt_n(pm_bus_n),
    .drive_en(pm_en));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic finish_test;
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic acc(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) chk(n, 0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge ref_clk);
  endtask

  function automatic logic pick(int k);
    case (k)
      0: return processor_clock_outputs[0];
      1: return gated_bus_clocks[0];
      2: return free_bus_clock;
      3: return reference_clock_outputs[0];
      4: return reference_clock_outputs[1];
      5: return interrupt_controller_clock;
      6: return usb_rate_clock[0];
      7: return usb_rate_clock[1];
      default: return memory_clock_outputs[0];
    endcase
  endfunction

  function automatic int exp_p(int k);
    case (k)
      0, 8: return 2 * hp;
      1, 2: return 4 * hp;
      6: return 2 * HU * (cfg[`SCG_CFG0_USB0_BIT] ? 2 : 1);
      7: return 2 * HU * (cfg[`SCG_CFG0_USB1_BIT] ? 2 : 1);
      default: return 2 * HR;
    endcase
  endfunction

  // Rise-to-rise period in ref_clk cycles
  task automatic per(input int k, output int p);
    logic pv;
    int n;
    n = 0;
    do begin
      pv = pick(k);
      @(posedge ref_clk);
      n++;
    end while (!(pv === 1'b0 && pick(k) === 1'b1) && n < 400);
    p = 0;
    do begin
      pv = pick(k);
      @(posedge ref_clk);
      p++;
    end while (!(pv === 1'b0 && pick(k) === 1'b1) && p < 400);
  endtask

  // Changes a halt pin, counts free rises before the gated change
  task automatic halt_run(input int g, input logic lvl, input int hh, output int at);
    int n, hw, rk;
    logic pr, pt;
    rk = (g != 0) ? 2 : 8;
    n = 0;
    hw = -999;
    at = -1;
    pr = pick(rk);
    pt = pick(g);
    if (g == 0) proc_req <= ~lvl;
    else bus_req <= ~lvl;
    repeat (120) begin
      @(posedge ref_clk);
      if (pt === 1'b1 && pick(g) === 1'b0) begin
        if (hw > 0) chk(hw, hh);
        if (!lvl) at = n;
      end
      if (lvl && pt === 1'b0 && pick(g) === 1'b1 && at < 0) at = n;
      if (pick(g) === 1'b1) hw++;
      else hw = 0;
      if (pr === 1'b0 && pick(rk) === 1'b1) n++;
      pr = pick(rk);
      pt = pick(g);
    end
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (30000) @(posedge ref_clk);
    error_cnt++;
    finish_test;
  end

  initial begin
    int p, k, at;
    logic [31:0] q;
    void'($urandom(79));
    repeat (5) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (10) @(posedge ref_clk);
    acc(1'b0, `SCG_OFS_CFG0, 32'h0, 4'hf, q);
    chk(q, `SCG_CFG0_RESET);
    acc(1'b0, `SCG_OFS_CFG7, 32'h0, 4'hf, q);
    chk(q, `SCG_CFG7_RESET);
    acc(1'b1, `SCG_OFS_CFG0, 32'hc, 4'h0, q);
    acc(1'b1, 4'hc, 32'hff, 4'hf, q);
    acc(1'b0, 4'hc, 32'h0, 4'hf, q);
    chk(q, 32'h0);
    acc(1'b0, `SCG_OFS_CFG0, 32'h0, 4'hf, q);
    chk(q, 32'h0);
    for (k = 0; k < 9; k++) begin
      per(k, p);
      chk(p, exp_p(k));
    end
    repeat (40) begin
      @(posedge ref_clk);
      chk({memory_clock_outputs, processor_clock_outputs}, {10{pick(0)}});
    end
    base_frequency_select <= 1'b1;
    hp = H66;
    repeat (30) @(posedge ref_clk);
    for (k = 0; k < 3; k++) begin
      per(k, p);
      chk(p, exp_p(k));
    end
    for (k = 0; k < 4; k++) begin
      cfg = (k == 0) ? 32'hc : ($urandom & 32'hc);
      acc(1'b1, `SCG_OFS_CFG0, cfg, 4'h1, q);
      repeat (40) @(posedge ref_clk);
      per(6, p);
      chk(p, exp_p(6));
      per(7, p);
      chk(p, exp_p(7));
    end
    acc(1'b1, `SCG_OFS_CFG7, 32'h0, 4'h1, q);
    base_frequency_select <= 1'b0;
    repeat (30) @(posedge ref_clk);
    per(0, p);
    chk(p, 2 * H66);
    acc(1'b1, `SCG_OFS_CFG7, 32'h7, 4'h1, q);
    hp = H60;
    repeat (30) @(posedge ref_clk);
    per(0, p);
    chk(p, 2 * H60);
    chk({mem6_pin_oe_n, mem7_pin_oe_n}, 2'b11);
    halt_run(0, 1'b0, H60, at);
    chk(at >= 2 && at <= 3, 1);
    chk({pick(0), processor_clock_outputs}, 0);
    acc(1'b0, `SCG_OFS_STATUS, 32'h0, 4'hf, q);
    chk(q, 32'h4);
    per(2, p);
    chk(p, 4 * H60);
    per(3, p);
    chk(p, 2 * HR);
    halt_run(0, 1'b1, H60, at);
    chk(at >= 2 && at <= 3, 1);
    halt_run(1, 1'b0, 2 * H60, at);
    chk(at >= 1 && at <= 2, 1);
    chk(gated_bus_clocks, 0);
    per(2, p);
    chk(p, 4 * H60);
    halt_run(1, 1'b1, 2 * H60, at);
    chk(at >= 1 && at <= 2, 1);
    mode_select <= 1'b1;
    proc_req <= 1'b1;
    bus_req <= 1'b1;
    repeat (40) @(posedge ref_clk);
    chk({mem6_pin_oe_n, mem7_pin_oe_n}, 2'b00);
    repeat (30) begin
      @(posedge ref_clk);
      chk({mem6_pin_out, mem7_pin_out}, {2{pick(8)}});
    end
    per(0, p);
    chk(p, 2 * H60);
    per(1, p);
    chk(p, 4 * H60);
    acc(1'b0, `SCG_OFS_STATUS, 32'h0, 4'hf, q);
    chk(q, 32'h7);
    finish_test;
  end
endmodule
